// ==== verilog/hdc_pkg.sv ====
// Purpose: constants shared by the haptic drive control register bank
// Assumes: 8-bit registers reached over the host serial port decoder
// Notes:   times are kept in microseconds, counts derive in the top
// Function
// - control one at 0x1b, fixed bit layout
// - control two at 0x1c, fixed bit layout
// - boost bit raises overdrive loop gain
// - common-mode bit turns on input bias
// - resonant drive time is code*0.1+0.5 ms
// - drive time seeds then self-adjusts
// - rotating-mass sample period is code*0.2+1 ms
// - direction bit picks uni or bidirectional
// - unidirectional uses full range as magnitude
// - unidirectional zero gives none, half gives half
// - bidirectional open-loop: below half brakes
// - stabilizer lowers gain near brake end
// - sampling code selects 150 to 300 us
package hdc_pkg;
  // register addresses
  localparam logic [7:0] HDC_ADDR_ONE   = 8'h1b;
  localparam logic [7:0] HDC_ADDR_TWO   = 8'h1c;
  // reset values of both registers
  localparam logic [7:0] HDC_RST_ONE    = 8'h93;
  localparam logic [7:0] HDC_RST_TWO    = 8'hf5;
  // control one field positions
  localparam int         HDC_BOOST_BIT  = 7;
  localparam int         HDC_RSVD_BIT   = 6;
  localparam int         HDC_CM_BIT     = 5;
  localparam int         HDC_DT_MSB     = 4;
  // control two field positions
  localparam int         HDC_DIR_BIT    = 7;
  localparam int         HDC_STAB_BIT   = 6;
  localparam int         HDC_SAMP_LSB   = 4;
  localparam int         HDC_BLANK_LSB  = 2;
  localparam int         HDC_DISS_LSB   = 0;
  // clock rate and drive times
  localparam int         HDC_CLK_MHZ    = 200;
  localparam int         HDC_LRA_STEP_US = 100;
  localparam int         HDC_LRA_BASE_US = 500;
  localparam int         HDC_ERM_STEP_US = 200;
  localparam int         HDC_ERM_BASE_US = 1000;
  localparam int         HDC_SAMP_BASE_US = 150;
  localparam int         HDC_SAMP_STEP_US = 50;
  // datapath widths
  localparam int         HDC_CYC_W      = 24;
  localparam int         HDC_AMP_W      = 8;
  // amplitude midpoint of the unsigned input range
  localparam logic [8:0] HDC_AMP_MID    = 9'h080;
endpackage : hdc_pkg

// ==== verilog/hdc_amp_map.sv ====
// Purpose: maps incoming amplitude codes onto a signed drive level
// Assumes: amplitude arrives on core_clk from the playback engine
// Notes:   level is 10-bit signed, full scale about +/-256
module hdc_amp_map (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // mode selects
  input  wire logic                 signed_input_select,
  input  wire logic                 closed_loop,
  // amplitude in and level out
  input  wire logic [7:0]           amp_in,
  output logic signed [9:0]         drive_level_q
);
  import hdc_pkg::*;

  // amplitude centred on half scale, doubled to full range
  wire signed [9:0] centred  = 10'(signed'({1'b0, amp_in}))
                             - 10'(signed'(HDC_AMP_MID));
  wire signed [9:0] bidir_lv = centred <<< 1;
  wire              below    = ~amp_in[HDC_AMP_W-1];
  wire signed [9:0] uni_lv   = 10'({2'b00, amp_in});
  // closed-loop bidirectional clips braking half to nothing
  wire signed [9:0] closed_lv = below ? 10'sh000 : bidir_lv;
  wire signed [9:0] level_d  =
    !signed_input_select ? uni_lv :
    (closed_loop ? closed_lv : bidir_lv);

  // register the level
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      drive_level_q <= 10'sh000;
    end else begin
      drive_level_q <= level_d;
    end
  end

  uni_scale_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !signed_input_select |=> drive_level_q == 10'($past(amp_in)))
    else $error("unidirectional level wrong");
  bidir_mid_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    signed_input_select && !closed_loop && amp_in == 8'h80
    |=> drive_level_q == 10'sh000)
    else $error("bidirectional midpoint not zero");
  bidir_brake_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    signed_input_select && !closed_loop && amp_in == 8'h00
    |=> drive_level_q == -10'sd256)
    else $error("bidirectional zero not full brake");
  brake_seen_c: cover property (@(posedge core_clk) drive_level_q < 0);
endmodule : hdc_amp_map

// ==== verilog/hdc_ctrl_regs.sv ====
// Purpose: control registers one and two of the haptic driver
// Assumes: serial port decoder on core_clk gives address and strobes
// Notes:   read data follows a read strobe by one cycle
module hdc_ctrl_regs #(
  parameter int LRA_STEP_CYC  = hdc_pkg::HDC_LRA_STEP_US
                                * hdc_pkg::HDC_CLK_MHZ,
  parameter int LRA_BASE_CYC  = hdc_pkg::HDC_LRA_BASE_US
                                * hdc_pkg::HDC_CLK_MHZ,
  parameter int ERM_STEP_CYC  = hdc_pkg::HDC_ERM_STEP_US
                                * hdc_pkg::HDC_CLK_MHZ,
  parameter int ERM_BASE_CYC  = hdc_pkg::HDC_ERM_BASE_US
                                * hdc_pkg::HDC_CLK_MHZ,
  parameter int SAMP_BASE_CYC = hdc_pkg::HDC_SAMP_BASE_US
                                * hdc_pkg::HDC_CLK_MHZ,
  parameter int SAMP_STEP_CYC = hdc_pkg::HDC_SAMP_STEP_US
                                * hdc_pkg::HDC_CLK_MHZ,
  parameter int ADJ_STEP_CYC  = 64
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // register port from the serial decoder
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr_en,
  input  wire logic [7:0]           reg_wr_data,
  input  wire logic                 reg_rd_en,
  output logic [7:0]                reg_rd_data_q,
  output logic                      reg_rd_valid_q,
  // loop status from the feedback engine
  input  wire logic                 lra_mode,
  input  wire logic                 closed_loop,
  input  wire logic                 overdrive_phase,
  input  wire logic                 brake_near_done,
  input  wire logic                 adj_pulse,
  input  wire logic                 adj_longer,
  input  wire logic [7:0]           amp_in,
  // configuration outputs
  output logic                      input_common_mode_enable_q,
  output logic                      high_gain_q,
  output logic                      low_gain_q,
  output logic                      signed_input_select_q,
  output logic [1:0]                sense_blank_interval_q,
  output logic [1:0]                current_dissipation_interval_q,
  output logic [hdc_pkg::HDC_CYC_W-1:0] sample_cyc_q,
  output logic [hdc_pkg::HDC_CYC_W-1:0] drive_cyc_q,
  output logic                      drive_tick_q,
  output logic signed [9:0]         drive_level_q
);
  import hdc_pkg::*;

  // period in cycles from a code, a step and a base
  function automatic logic [HDC_CYC_W-1:0] hdc_period(
    input logic [4:0] code,
    input int         step,
    input int         base
  );
    hdc_period = HDC_CYC_W'(code) * HDC_CYC_W'(step)
               + HDC_CYC_W'(base);
  endfunction : hdc_period

  // stored fields
  logic                 boost_q;      // overdrive gain boost
  logic                 cm_q;         // common-mode bias enable
  logic [4:0]           dt_q;         // drive-time code
  logic                 dir_q;        // bidirectional select
  logic                 stab_q;       // brake loop damping
  logic [1:0]           samp_q;       // sampling time code
  logic [1:0]           blank_q;      // blanking code
  logic [1:0]           diss_q;       // dissipation code
  logic                 seed_q;       // reseed after reset or a control one write
  logic                 mode_q;       // last actuator mode
  logic [HDC_CYC_W-1:0] tick_cnt_q;   // drive period counter

  // address decode
  wire hit_one = reg_addr == HDC_ADDR_ONE;
  wire hit_two = reg_addr == HDC_ADDR_TWO;
  wire wr_one  = reg_wr_en && hit_one;
  wire wr_two  = reg_wr_en && hit_two;

  // control one image, reserved reads zero
  wire [7:0] img_one = {boost_q, 1'b0, cm_q, dt_q};
  wire [7:0] img_two = {dir_q, stab_q, samp_q, blank_q, diss_q};
  wire [7:0] rd_mux  = hit_one ? img_one : (hit_two ? img_two : 8'h00);

  // drive time targets and bounds for the active mode
  wire [HDC_CYC_W-1:0] tgt_lra = hdc_period(dt_q, LRA_STEP_CYC,
                                            LRA_BASE_CYC);
  wire [HDC_CYC_W-1:0] tgt_erm = hdc_period(dt_q, ERM_STEP_CYC,
                                            ERM_BASE_CYC);
  wire [HDC_CYC_W-1:0] tgt     = lra_mode ? tgt_lra : tgt_erm;
  wire [HDC_CYC_W-1:0] lra_min = hdc_period(5'h00, LRA_STEP_CYC,
                                            LRA_BASE_CYC);
  wire [HDC_CYC_W-1:0] lra_max = hdc_period(5'h1f, LRA_STEP_CYC,
                                            LRA_BASE_CYC);
  wire [HDC_CYC_W-1:0] adj     = HDC_CYC_W'(ADJ_STEP_CYC);
  wire can_up = drive_cyc_q + adj <= lra_max;
  wire can_dn = drive_cyc_q >= lra_min + adj;
  // a control one write reseeds one cycle late, once the new code is stored;
  // seeding in the write cycle itself would load the old code
  wire seed   = seed_q || (lra_mode != mode_q);
  wire tick_end = tick_cnt_q + HDC_CYC_W'(1) >= drive_cyc_q;
  wire [HDC_CYC_W-1:0] samp_d = HDC_CYC_W'(SAMP_BASE_CYC)
                              + HDC_CYC_W'(samp_q)
                              * HDC_CYC_W'(SAMP_STEP_CYC);

  // control one storage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      boost_q <= HDC_RST_ONE[HDC_BOOST_BIT];
      cm_q    <= HDC_RST_ONE[HDC_CM_BIT];
      dt_q    <= HDC_RST_ONE[HDC_DT_MSB:0];
    end else if (wr_one) begin
      boost_q <= reg_wr_data[HDC_BOOST_BIT];
      cm_q    <= reg_wr_data[HDC_CM_BIT];
      dt_q    <= reg_wr_data[HDC_DT_MSB:0];
    end
  end

  // control two storage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      {dir_q, stab_q, samp_q, blank_q, diss_q} <= HDC_RST_TWO;
    end else if (wr_two) begin
      dir_q   <= reg_wr_data[HDC_DIR_BIT];
      stab_q  <= reg_wr_data[HDC_STAB_BIT];
      samp_q  <= reg_wr_data[HDC_SAMP_LSB+:2];
      blank_q <= reg_wr_data[HDC_BLANK_LSB+:2];
      diss_q  <= reg_wr_data[HDC_DISS_LSB+:2];
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rd_data_q  <= 8'h00;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data_q <= rd_mux;
      end
    end
  end

  // gain, bias, direction, interval and sampling outputs
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      input_common_mode_enable_q     <= 1'b0;
      high_gain_q                    <= 1'b0;
      low_gain_q                     <= 1'b0;
      signed_input_select_q          <= HDC_RST_TWO[HDC_DIR_BIT];
      sense_blank_interval_q         <= 2'h0;
      current_dissipation_interval_q <= 2'h0;
      sample_cyc_q                   <= '0;
    end else begin
      input_common_mode_enable_q     <= cm_q;
      high_gain_q                    <= boost_q && overdrive_phase;
      low_gain_q                     <= stab_q && brake_near_done;
      signed_input_select_q          <= dir_q;
      sense_blank_interval_q         <= blank_q;
      current_dissipation_interval_q <= diss_q;
      sample_cyc_q                   <= samp_d;
    end
  end

  // working drive time, seeded then tracked
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      drive_cyc_q <= '0;
      seed_q      <= 1'b1;
      mode_q      <= 1'b0;
    end else begin
      seed_q <= wr_one;
      mode_q <= lra_mode;
      if (seed) begin
        drive_cyc_q <= tgt;
      end else if (lra_mode && adj_pulse) begin
        if (adj_longer && can_up) begin
          drive_cyc_q <= drive_cyc_q + adj;
        end else if (!adj_longer && can_dn) begin
          drive_cyc_q <= drive_cyc_q - adj;
        end
      end
    end
  end

  // drive period tick: half-period or back-EMF sample point
  always_ff @(posedge core_clk) begin
    if (!reset_n || seed) begin
      tick_cnt_q   <= '0;
      drive_tick_q <= 1'b0;
    end else begin
      drive_tick_q <= tick_end;
      tick_cnt_q   <= tick_end ? '0 : tick_cnt_q + HDC_CYC_W'(1);
    end
  end

  // amplitude interpretation
  hdc_amp_map u_amp_map (
    .core_clk            (core_clk),
    .reset_n             (reset_n),
    .signed_input_select (dir_q),
    .closed_loop         (closed_loop),
    .amp_in              (amp_in),
    .drive_level_q       (drive_level_q)
  );

  // control one readback, image as it stood at the strobe
  rd_one_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_rd_en && hit_one
    |=> reg_rd_valid_q && reg_rd_data_q == $past(img_one))
    else $error("control one readback wrong");
  rd_two_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_rd_en && hit_two
    |=> reg_rd_valid_q && reg_rd_data_q == $past(img_two))
    else $error("control two readback wrong");
  rsvd_zero_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_rd_en && hit_one |=> reg_rd_data_q[HDC_RSVD_BIT] == 1'b0)
    else $error("reserved bit not zero");
  wr_back_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wr_two |=> img_two == $past(reg_wr_data))
    else $error("control two not written");
  // defaults after reset, watched while reset is low
  rst_dflt_a: assert property (
    @(posedge core_clk)
    !reset_n
    |=> img_one == (HDC_RST_ONE & 8'hbf) && img_two == HDC_RST_TWO)
    else $error("reset defaults wrong");
  cm_bias_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wr_one ##1 !wr_one |=> input_common_mode_enable_q
    == $past(reg_wr_data[HDC_CM_BIT], 2))
    else $error("bias enable not following write");
  boost_gain_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    overdrive_phase && boost_q |=> high_gain_q)
    else $error("boost gain missing in overdrive");
  damp_gain_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !brake_near_done || !stab_q |=> !low_gain_q)
    else $error("damping gain out of place");
  // direction select follows the stored bit
  sel_out_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> signed_input_select_q == $past(dir_q))
    else $error("direction select not following");
  lra_seed_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seed && lra_mode |=> drive_cyc_q == HDC_CYC_W'($past(dt_q))
    * HDC_CYC_W'(LRA_STEP_CYC) + HDC_CYC_W'(LRA_BASE_CYC))
    else $error("resonant drive time seed wrong");
  erm_seed_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    seed && !lra_mode |=> drive_cyc_q == HDC_CYC_W'($past(dt_q))
    * HDC_CYC_W'(ERM_STEP_CYC) + HDC_CYC_W'(ERM_BASE_CYC))
    else $error("back-emf period seed wrong");
  adj_up_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !seed && lra_mode && adj_pulse && adj_longer && can_up
    |=> drive_cyc_q == $past(drive_cyc_q) + adj)
    else $error("drive time not lengthened");
  adj_dn_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !seed && lra_mode && adj_pulse && !adj_longer && can_dn
    |=> drive_cyc_q == $past(drive_cyc_q) - adj)
    else $error("drive time not shortened");
  samp_time_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    wr_two ##1 !wr_two ##1 1 |-> sample_cyc_q == HDC_CYC_W'(SAMP_BASE_CYC)
    + HDC_CYC_W'($past(reg_wr_data[HDC_SAMP_LSB+:2], 2))
    * HDC_CYC_W'(SAMP_STEP_CYC))
    else $error("sampling time wrong");

  wr_one_c: cover property (@(posedge core_clk) wr_one ##1 reg_rd_en);
  tick_c: cover property (@(posedge core_clk) drive_tick_q);
  adj_c: cover property (@(posedge core_clk) lra_mode && adj_pulse);
  seed_c: cover property (@(posedge core_clk) seed_q && reset_n);
endmodule : hdc_ctrl_regs

// ==== tb/hdc_ctrl_regs_tb_top.sv ====
// Purpose: self-checking bench for the haptic drive control registers
// Assumes: short cycle parameters keep every drive count small
// Notes:   inputs change on rising edges by non-blocking assignment
module hdc_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hdc_pkg::*;
  // shortened cycle counts handed to the design
  localparam int LS = 4;
  localparam int LB = 20;
  localparam int ES = 8;
  localparam int EB = 40;
  localparam int SB = 6;
  localparam int SS = 2;
  localparam int AS = 2;
  // stimulus and observed signals
  logic                 core_clk, reset_n;
  logic [7:0]           reg_addr, reg_wr_data, rd_q, amp_in;
  logic                 reg_wr_en, reg_rd_en, rd_vld_q;
  logic                 lra_mode, closed_loop, overdrive_phase;
  logic                 brake_near_done, adj_pulse, adj_longer;
  logic                 cm_q, hi_q, lo_q, sel_q, tick_q;
  logic [1:0]           blank_q, diss_q;
  logic [HDC_CYC_W-1:0] samp_q, drv_q;
  logic signed [9:0]    level_q;
  logic [7:0]           d;
  int                   n_fail, n_checks;

  hdc_ctrl_regs #(
    .LRA_STEP_CYC(LS), .LRA_BASE_CYC(LB), .ERM_STEP_CYC(ES),
    .ERM_BASE_CYC(EB), .SAMP_BASE_CYC(SB), .SAMP_STEP_CYC(SS),
    .ADJ_STEP_CYC(AS)
  ) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data_q(rd_q),
    .reg_rd_valid_q(rd_vld_q), .lra_mode(lra_mode),
    .closed_loop(closed_loop), .overdrive_phase(overdrive_phase),
    .brake_near_done(brake_near_done), .adj_pulse(adj_pulse),
    .adj_longer(adj_longer), .amp_in(amp_in),
    .input_common_mode_enable_q(cm_q), .high_gain_q(hi_q),
    .low_gain_q(lo_q), .signed_input_select_q(sel_q),
    .sense_blank_interval_q(blank_q),
    .current_dissipation_interval_q(diss_q), .sample_cyc_q(samp_q),
    .drive_cyc_q(drv_q), .drive_tick_q(tick_q), .drive_level_q(level_q)
  );

  // free-running 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // verdict and end of run
  task automatic close_out;
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // single comparison point
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // let n edges pass, then step clear of them
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  // one write strobe, fields land at the strobe edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr    <= a;
    reg_wr_data <= v;
    reg_wr_en   <= 1'b1;
    @(posedge core_clk);
    reg_wr_en   <= 1'b0;
    wait_cyc(2);
  endtask : wr

  // one read strobe, answer expected exactly one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    check("read valid", rd_vld_q, 1'b1);
    v = rd_q;
  endtask : rd

  // one-cycle drive-time adjust request
  task automatic adj(input logic longer);
    @(posedge core_clk);
    adj_pulse  <= 1'b1;
    adj_longer <= longer;
    @(posedge core_clk);
    adj_pulse  <= 1'b0;
    wait_cyc(2);
  endtask : adj

  // present an amplitude and let the level settle
  task automatic lvl(input logic [7:0] a);
    @(posedge core_clk);
    amp_in <= a;
    wait_cyc(2);
  endtask : lvl

  // defaults after reset
  task automatic t_reset;
    rd(HDC_ADDR_ONE, d);
    check("one reset", d, 8'h93);
    rd(HDC_ADDR_TWO, d);
    check("two reset", d, 8'hf5);
    check("dir reset", sel_q, 1'b1);
    check("cm reset", cm_q, 1'b0);
    check("samp reset", samp_q, 24'(SB + 3 * SS));
    check("drive seed", drv_q, 24'(19 * LS + LB));
  endtask : t_reset

  // bit layout, reserved bit and unmapped places
  task automatic t_layout;
    // bias set only as if the input were analog
    wr(HDC_ADDR_ONE, 8'hff);
    rd(HDC_ADDR_ONE, d);
    check("one rsvd", d, 8'hbf);
    check("cm on", cm_q, 1'b1);
    wr(HDC_ADDR_ONE, 8'h00);
    check("cm off", cm_q, 1'b0);
    wr(HDC_ADDR_TWO, 8'h6d);
    rd(HDC_ADDR_TWO, d);
    check("two back", d, 8'h6d);
    check("dir field", sel_q, 1'b0);
    check("blank field", blank_q, 2'h3);
    check("diss field", diss_q, 2'h1);
    wr(8'h1d, 8'hff);
    rd(8'h1d, d);
    check("unmapped", d, 8'h00);
    rd(HDC_ADDR_ONE, d);
    check("one kept", d, 8'h00);
  endtask : t_layout

  // every sampling code
  task automatic t_samp;
    for (int c = 0; c < 4; c++) begin
      wr(HDC_ADDR_TWO, {2'b11, 2'(c), 4'h5});
      check("samp code", samp_q, 24'(SB + c * SS));
    end
  endtask : t_samp

  // boost and damping gain selects
  task automatic t_gain;
    wr(HDC_ADDR_ONE, 8'h80);
    @(posedge core_clk);
    overdrive_phase <= 1'b1;
    brake_near_done <= 1'b1;
    wait_cyc(2);
    check("boost on", hi_q, 1'b1);
    wr(HDC_ADDR_ONE, 8'h13);
    check("boost off", hi_q, 1'b0);
    wr(HDC_ADDR_TWO, 8'h40);
    check("damp on", lo_q, 1'b1);
    @(posedge core_clk);
    brake_near_done <= 1'b0;
    wait_cyc(2);
    check("damp idle", lo_q, 1'b0);
    @(posedge core_clk);
    overdrive_phase <= 1'b0;
  endtask : t_gain

  // drive time per mode, with the lower adjustment bound
  task automatic t_drive;
    // codes stand for about half the actuator period
    wr(HDC_ADDR_ONE, 8'h1f);
    check("lra top", drv_q, 24'(31 * LS + LB));
    wr(HDC_ADDR_ONE, 8'h00);
    check("lra base", drv_q, 24'(LB));
    adj(1'b1);
    check("adj longer", drv_q, 24'(LB + AS));
    adj(1'b0);
    adj(1'b0);
    check("adj floor", drv_q, 24'(LB));
    @(posedge core_clk);
    lra_mode <= 1'b0;
    wr(HDC_ADDR_ONE, 8'h05);
    check("erm period", drv_q, 24'(5 * ES + EB));
    adj(1'b1);
    check("erm no adj", drv_q, 24'(5 * ES + EB));
    @(posedge core_clk);
    lra_mode <= 1'b1;
    wr(HDC_ADDR_ONE, 8'h00);
  endtask : t_drive

  // tick spacing equals the seeded drive time
  task automatic t_tick;
    int k;
    k = 0;
    while (tick_q !== 1'b1 && k < 200) begin
      wait_cyc(1);
      k++;
    end
    if (k >= 200) begin
      n_fail++;
      close_out();
    end
    k = 0;
    do begin
      wait_cyc(1);
      k++;
    end while (tick_q !== 1'b1 && k < 200);
    if (k >= 200) begin
      n_fail++;
      close_out();
    end
    check("tick period", 24'(k), 24'(LB));
  endtask : t_tick

  // amplitude mapping in each direction mode
  task automatic t_amp;
    // unidirectional, checked with closed_loop high, which it ignores
    wr(HDC_ADDR_TWO, 8'h00);
    lvl(8'h00);
    check("uni zero", {14'h0, level_q}, 24'h000);
    lvl(8'h80);
    check("uni half", {14'h0, level_q}, 24'h080);
    lvl(8'hff);
    check("uni full", {14'h0, level_q}, 24'h0ff);
    @(posedge core_clk);
    closed_loop <= 1'b0;
    wr(HDC_ADDR_TWO, 8'h80);
    lvl(8'h80);
    check("bi half", {14'h0, level_q}, 24'h000);
    lvl(8'h00);
    check("bi brake", {14'h0, level_q}, 24'h300);
    lvl(8'h40);
    check("bi quarter", {14'h0, level_q}, 24'h380);
    // closed-loop bidirectional: lower half gives nothing
    @(posedge core_clk);
    closed_loop <= 1'b1;
    lvl(8'h40);
    check("closed low", {14'h0, level_q}, 24'h000);
    lvl(8'hc0);
    check("closed high", {14'h0, level_q}, 24'h080);
  endtask : t_amp

  // second reset in mid-run brings every default back
  task automatic t_rerst;
    wr(HDC_ADDR_ONE, 8'h00);
    wr(HDC_ADDR_TWO, 8'h00);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_cyc(3);
    rd(HDC_ADDR_ONE, d);
    check("one rerst", d, 8'h93);
    rd(HDC_ADDR_TWO, d);
    check("two rerst", d, 8'hf5);
    check("rerst seed", drv_q, 24'(19 * LS + LB));
  endtask : t_rerst

  // main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    lra_mode = 1'b1;
    closed_loop = 1'b1;
    overdrive_phase = 1'b0;
    brake_near_done = 1'b0;
    adj_pulse = 1'b0;
    adj_longer = 1'b0;
    amp_in = 8'h00;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_cyc(3);
    t_reset();
    t_layout();
    t_samp();
    t_gain();
    t_drive();
    t_tick();
    t_amp();
    t_rerst();
    close_out();
  end
endmodule : hdc_ctrl_regs_tb_top
